// ==== design/sc_level_cmp.sv ====
// One sandcastle threshold comparator with edge outputs
`timescale 1ns/1ps
`default_nettype none
module sc_level_cmp #(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_sample,
   input  wire logic [W-1:0] i_threshold,
   input  wire logic         i_enable,
   output var  logic         o_level,
   output var  logic         o_rise,
   output var  logic         o_fall
);
   sc_seq_pkg::cmp_state_t st_reg;
   sc_seq_pkg::cmp_state_t st_next;

   // High only while the sample is above the threshold
   always_comb begin
      st_next       = st_reg;
      st_next.level = i_enable && (i_sample > i_threshold);
      st_next.prev  = st_reg.level;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Edges one cycle wide, both from flops
   assign o_level = st_reg.level;
   assign o_rise  = st_reg.level && !st_reg.prev;
   assign o_fall  = !st_reg.level && st_reg.prev;

   a_level_tracks: assert property (@(posedge i_clk) disable iff (i_rst)
      o_level == $past(i_enable && (i_sample > i_threshold)))
      else $error("comparator level does not follow its input");
endmodule : sc_level_cmp
`default_nettype wire

// ==== design/sc_seq_map.svh ====
// Register map, field positions and sandcastle thresholds of the sequencer
`ifndef SC_SEQ_MAP_SVH
`define SC_SEQ_MAP_SVH
// Contract
// - Three thresholds in three-level mode, two when two-level select is set.
// - Each decoded pulse is high exactly while the input exceeds its threshold.
// - Vertical needs two key pulses (two-level) or two line pulses (three-level).
// - Line counter starts at the leading edge of the identified vertical.
// - Vertical blanking applies only to a detected vertical pulse.
// - Blank is vertical pulse OR the gate lasting until measurement lines end.
// - Leakage line starts after the horizontal pulse following vertical end.
// - After leakage: red on next line, green second, blue third.
// - During blank period channels go ultra-black except own measurement line.
// - Insertion lasts a full line; window is line minus horizontal pulse.
// - Control bit picks luma or hue on aux output; hue mode has no sync.
// - Hue level is a 6-bit value at bus subaddress 03H.
// - Dark window from line 16 to 224 or 272, doubled at double rate.

// Register byte addresses
`define REG_CTRL        32'h0000_0000
`define REG_STATUS      32'h0000_0004
`define HUE_INDEX       32'h0000_0003
`define REG_HUE         (`HUE_INDEX * 32'h0000_0004)

// Control register fields
`define CTRL_TWO_LEVEL  0
`define CTRL_LUMA_SEL   1
`define CTRL_NTSC       2
`define CTRL_DOUBLE     3
`define CTRL_RESET      4'h2
`define HUE_RESET       6'h3F

// Status register fields
`define STAT_STATE_LSB  0
`define STAT_GATE       3
`define STAT_RUN        4
`define STAT_LINE_LSB   16

// Sandcastle thresholds, sample codes
`define THR3_LOW        8'h30
`define THR3_MID        8'h70
`define THR3_KEY        8'hC0
`define THR2_LOW        8'h50
`define THR2_KEY        8'hB0

// Line counts
`define VERT_MIN_PULSES 2'h2
`define DARK_FIRST      10'h010
`define DARK_LAST_NTSC  10'h0E0
`define DARK_LAST_PAL   10'h110

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ==== design/sc_seq_pkg.sv ====
// Types shared by the sandcastle measurement sequencer
package sc_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_VERT   = 3'b001,
      ST_WAIT_H = 3'b010,
      ST_LEAK   = 3'b011,
      ST_RED    = 3'b100,
      ST_GREEN  = 3'b101,
      ST_BLUE   = 3'b110
   } seq_state_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_rsp_t;

   typedef struct packed {
      logic leak;
      logic red;
      logic green;
      logic blue;
   } meas_lines_t;

   typedef struct packed {
      logic level;
      logic prev;
   } cmp_state_t;

   typedef struct packed {
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      seq_state_t  state;
      logic [1:0]  pulse_cnt;
      logic [9:0]  line_cnt;
      logic        cnt_run;
      logic        gate;
      logic        aw_held;
      logic [31:0] awaddr;
      logic        w_held;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [3:0]  ctrl;
      logic [5:0]  hue;
   } core_state_t;
endpackage : sc_seq_pkg

// ==== design/sc_seq_top.sv ====
// Sandcastle decoder, line counter and cut-off measurement line sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sc_seq_map.svh"
module sc_seq_top (
   input  wire logic                   I_MCLK,
   input  wire logic                   I_RST,
   input  wire logic [7:0]             I_SC_SAMPLE,
   input  wire sc_seq_pkg::axi_req_t   I_AXI,
   output var  sc_seq_pkg::axi_rsp_t   O_AXI,
   output var  sc_seq_pkg::meas_lines_t O_LINES,
   output var  logic                   O_MEAS_WINDOW,
   output var  logic                   O_BLANK,
   output var  logic                   O_BLANK_PERIOD,
   output var  logic [2:0]             O_FORCE_BLACK,
   output var  logic                   O_DARK_WINDOW,
   output var  logic                   O_AUX_LUMA,
   output var  logic                   O_SYNC_EN,
   output var  logic [5:0]             O_HUE_LEVEL
);
   sc_seq_pkg::core_state_t r;
   sc_seq_pkg::core_state_t n;

   logic       two_level;
   logic       luma_sel;
   logic       lo_lvl;
   logic       lo_rise;
   logic       lo_fall;
   logic       mid_lvl;
   logic       mid_rise;
   logic       mid_fall;
   logic       key_rise;
   logic [7:0] thr_low;
   logic [7:0] thr_key;
   logic       line_pulse;
   logic       h_lvl;
   logic       h_fall;
   logic       ident;
   logic       v_active;
   logic       in_meas;
   logic [9:0] dark_first;
   logic [9:0] dark_last;
   logic       hue_write;

   // ********************************************
   // Sandcastle level separation
   // ********************************************

   // Two-level mode drops the middle comparator
   assign two_level = r.ctrl[`CTRL_TWO_LEVEL];
   assign luma_sel  = r.ctrl[`CTRL_LUMA_SEL];
   assign thr_low   = two_level ? `THR2_LOW : `THR3_LOW;
   assign thr_key   = two_level ? `THR2_KEY : `THR3_KEY;

   sc_level_cmp #(.W(8)) u_cmp_low (
      .i_clk       (I_MCLK),
      .i_rst       (I_RST),
      .i_sample    (r.sync2),
      .i_threshold (thr_low),
      .i_enable    (1'b1),
      .o_level     (lo_lvl),
      .o_rise      (lo_rise),
      .o_fall      (lo_fall)
   );

   sc_level_cmp #(.W(8)) u_cmp_mid (
      .i_clk       (I_MCLK),
      .i_rst       (I_RST),
      .i_sample    (r.sync2),
      .i_threshold (`THR3_MID),
      .i_enable    (!two_level),
      .o_level     (mid_lvl),
      .o_rise      (mid_rise),
      .o_fall      (mid_fall)
   );

   sc_level_cmp #(.W(8)) u_cmp_key (
      .i_clk       (I_MCLK),
      .i_rst       (I_RST),
      .i_sample    (r.sync2),
      .i_threshold (thr_key),
      .i_enable    (1'b1),
      .o_level     (),
      .o_rise      (key_rise),
      .o_fall      ()
   );

   // Line pulse: key in two-level, horizontal otherwise
   assign line_pulse = two_level ? key_rise : mid_rise;
   assign h_lvl      = two_level ? lo_lvl : mid_lvl;
   assign h_fall     = two_level ? lo_fall : mid_fall;

   // Second line pulse inside one low-level pulse marks vertical
   assign ident = lo_lvl && !lo_rise && line_pulse
                  && (r.pulse_cnt == `VERT_MIN_PULSES - 2'h1);

   assign v_active = (r.state == sc_seq_pkg::ST_VERT);
   assign in_meas  = (r.state == sc_seq_pkg::ST_LEAK)
                  || (r.state == sc_seq_pkg::ST_RED)
                  || (r.state == sc_seq_pkg::ST_GREEN)
                  || (r.state == sc_seq_pkg::ST_BLUE);

   // Dark window bounds, doubled at double rate
   assign dark_first = r.ctrl[`CTRL_DOUBLE] ? 10'(`DARK_FIRST << 1)
                                            : `DARK_FIRST;
   assign dark_last  = (r.ctrl[`CTRL_NTSC] ? `DARK_LAST_NTSC : `DARK_LAST_PAL)
                       << r.ctrl[`CTRL_DOUBLE];

   assign hue_write = r.aw_held && r.w_held && !r.bvalid
                      && (r.awaddr == `REG_HUE) && r.wstrb[0];

   // ********************************************
   // Next state
   // ********************************************
   always_comb begin
      n = r;
      // Pin sample crosses in on two flops
      n.sync1 = I_SC_SAMPLE;
      n.sync2 = r.sync1;

      // Count line pulses since the low leading edge
      if (lo_rise) begin
         n.pulse_cnt = line_pulse ? 2'h1 : 2'h0;
      end else if (lo_lvl && line_pulse && r.pulse_cnt != `VERT_MIN_PULSES) begin
         n.pulse_cnt = r.pulse_cnt + 2'h1;
      end

      // Counter measures lines from the vertical leading edge
      if (ident) begin
         n.line_cnt = 10'(`VERT_MIN_PULSES);
         n.cnt_run  = 1'b1;
      end else if (line_pulse && r.cnt_run && r.line_cnt != 10'h3FF) begin
         n.line_cnt = r.line_cnt + 10'h001;
      end

      // Measurement sequence, any new vertical restarts it
      if (ident) begin
         n.state = sc_seq_pkg::ST_VERT;
         n.gate  = 1'b1;
      end else begin
         case (r.state)
            sc_seq_pkg::ST_VERT: begin
               if (lo_fall) n.state = sc_seq_pkg::ST_WAIT_H;
            end
            sc_seq_pkg::ST_WAIT_H: begin
               if (h_fall) n.state = sc_seq_pkg::ST_LEAK;
            end
            sc_seq_pkg::ST_LEAK: begin
               if (h_fall) n.state = sc_seq_pkg::ST_RED;
            end
            sc_seq_pkg::ST_RED: begin
               if (h_fall) n.state = sc_seq_pkg::ST_GREEN;
            end
            sc_seq_pkg::ST_GREEN: begin
               if (h_fall) n.state = sc_seq_pkg::ST_BLUE;
            end
            sc_seq_pkg::ST_BLUE: begin
               if (h_fall) begin
                  n.state = sc_seq_pkg::ST_IDLE;
                  n.gate  = 1'b0;
               end
            end
            default: begin
               n.state = sc_seq_pkg::ST_IDLE;
            end
         endcase
      end

      // Write address and data land in either order
      if (I_AXI.awvalid && !r.aw_held) begin
         n.aw_held = 1'b1;
         n.awaddr  = I_AXI.awaddr;
      end
      if (I_AXI.wvalid && !r.w_held) begin
         n.w_held = 1'b1;
         n.wdata  = I_AXI.wdata;
         n.wstrb  = I_AXI.wstrb;
      end
      // Commit waits for a free response slot
      if (r.aw_held && r.w_held && !r.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = `RESP_OKAY;
         if (r.awaddr == `REG_CTRL) begin
            if (r.wstrb[0]) n.ctrl = r.wdata[3:0];
         end else if (r.awaddr == `REG_HUE) begin
            if (r.wstrb[0]) n.hue = r.wdata[5:0];
         end else if (r.awaddr == `REG_STATUS) begin
            n.bresp = `RESP_OKAY;
         end else begin
            n.bresp = `RESP_SLVERR;
         end
      end else if (r.bvalid && I_AXI.bready) begin
         n.bvalid = 1'b0;
      end

      // Reads answer the cycle after the address
      if (I_AXI.arvalid && !r.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp  = `RESP_OKAY;
         n.rdata  = 32'h0000_0000;
         if (I_AXI.araddr == `REG_CTRL) begin
            n.rdata[3:0] = r.ctrl;
         end else if (I_AXI.araddr == `REG_STATUS) begin
            n.rdata[`STAT_STATE_LSB +: 3] = r.state;
            n.rdata[`STAT_GATE]           = r.gate;
            n.rdata[`STAT_RUN]            = r.cnt_run;
            n.rdata[`STAT_LINE_LSB +: 10] = r.line_cnt;
         end else if (I_AXI.araddr == `REG_HUE) begin
            n.rdata[5:0] = r.hue;
         end else begin
            n.rresp = `RESP_SLVERR;
         end
      end else if (r.rvalid && I_AXI.rready) begin
         n.rvalid = 1'b0;
      end
   end

   // Control defaults to luma mode with hue at black level
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         r      <= '0;
         r.ctrl <= `CTRL_RESET;
         r.hue  <= `HUE_RESET;
      end else begin
         r <= n;
      end
   end

   // ********************************************
   // Outputs
   // ********************************************

   // Bus answers straight from flops
   assign O_AXI.awready = !r.aw_held;
   assign O_AXI.wready  = !r.w_held;
   assign O_AXI.bvalid  = r.bvalid;
   assign O_AXI.bresp   = r.bresp;
   assign O_AXI.arready = !r.rvalid;
   assign O_AXI.rvalid  = r.rvalid;
   assign O_AXI.rdata   = r.rdata;
   assign O_AXI.rresp   = r.rresp;

   // Insertion lines span full line periods
   assign O_LINES.leak  = (r.state == sc_seq_pkg::ST_LEAK);
   assign O_LINES.red   = (r.state == sc_seq_pkg::ST_RED);
   assign O_LINES.green = (r.state == sc_seq_pkg::ST_GREEN);
   assign O_LINES.blue  = (r.state == sc_seq_pkg::ST_BLUE);

   // Window drops out during the horizontal pulse
   assign O_MEAS_WINDOW = in_meas && !h_lvl;

   // Blank only for a recognised vertical
   assign O_BLANK        = v_active || r.gate;
   assign O_BLANK_PERIOD = r.gate;

   // Bit 0 red, 1 green, 2 blue
   assign O_FORCE_BLACK[0] = r.gate && !O_LINES.red;
   assign O_FORCE_BLACK[1] = r.gate && !O_LINES.green;
   assign O_FORCE_BLACK[2] = r.gate && !O_LINES.blue;

   // Peak dark detection idles while blanking
   // Bounds arrive already scaled, so doubling happens in one place only
   assign O_DARK_WINDOW = r.cnt_run && !O_BLANK
                          && (r.line_cnt >= dark_first)
                          && (r.line_cnt <= dark_last);

   // Hue mode carries no sync
   assign O_AUX_LUMA  = luma_sel;
   assign O_SYNC_EN   = luma_sel;
   assign O_HUE_LEVEL = r.hue;

   // ********************************************
   // Checks
   // ********************************************
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_RST);

   sequence s_leak_done;
      O_LINES.leak && h_fall && !ident;
   endsequence
   sequence s_red_done;
      O_LINES.red && h_fall && !ident;
   endsequence
   sequence s_green_done;
      O_LINES.green && h_fall && !ident;
   endsequence

   a_mid_off: assert property (two_level [*2] |-> !mid_lvl)
      else $error("middle threshold active in two-level mode");

   a_vert_ident: assert property ($rose(v_active) |->
      $past(r.pulse_cnt) == 2'h1 && $past(line_pulse) && $past(lo_lvl))
      else $error("vertical identified without two line pulses");

   a_line_restart: assert property (ident |=>
      v_active && r.line_cnt == 10'h002 && r.cnt_run)
      else $error("line counter not started at vertical");

   a_gate_cause: assert property ($rose(r.gate) |-> v_active)
      else $error("blank period without detected vertical");

   a_blank_busy: assert property (O_BLANK |-> r.state != sc_seq_pkg::ST_IDLE)
      else $error("blank raised while sequence idle");

   a_leak_start: assert property ($rose(O_LINES.leak) |->
      $past(r.state) == sc_seq_pkg::ST_WAIT_H && $past(h_fall))
      else $error("leakage line began at wrong point");

   a_color_order: assert property ((s_leak_done |=> O_LINES.red)
      and (s_red_done |=> O_LINES.green)
      and (s_green_done |=> O_LINES.blue))
      else $error("measurement lines out of order");

   a_black_red: assert property (O_LINES.red |->
      !O_FORCE_BLACK[0] && O_FORCE_BLACK[1] && O_FORCE_BLACK[2])
      else $error("channel blanking wrong on red line");

   a_window_gap: assert property (O_MEAS_WINDOW == ((O_LINES != '0) && !h_lvl))
      else $error("window open during horizontal pulse");

   a_insert_hold: assert property ((O_LINES.leak && !h_fall && !ident) |=> O_LINES.leak)
      else $error("insertion ended before line end");

   a_hue_nosync: assert property (!luma_sel |-> !O_SYNC_EN && !O_AUX_LUMA)
      else $error("sync present in hue mode");

   a_hue_write: assert property (hue_write |=> O_HUE_LEVEL == $past(r.wdata[5:0]))
      else $error("hue level not taken from write");

   a_dark_first: assert property (O_DARK_WINDOW |-> r.line_cnt >= 10'h010)
      else $error("dark window open before first line");

   a_seq_restart: assert property (ident && in_meas |=> v_active && r.gate)
      else $error("new vertical did not restart sequence");
endmodule : sc_seq_top
`default_nettype wire

// ==== verification/sandcastle_measurement_sequencer_bench.sv ====
// Self-checking bench of the sandcastle measurement sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sc_seq_map.svh"
module sandcastle_measurement_sequencer_bench;
   logic                    clk;
   logic                    rst;
   logic [7:0]              sample;
   sc_seq_pkg::axi_req_t    req;
   sc_seq_pkg::axi_rsp_t    rsp;
   sc_seq_pkg::meas_lines_t lines;
   logic                    win;
   logic                    blank;
   logic                    period;
   logic [2:0]              force_blk;
   logic                    dark;
   logic                    luma;
   logic                    sync;
   logic [5:0]              hue_lvl;
   logic [5:0]              hue;
   logic [15:0]             lfsr;
   logic [3:0]              exp_l;
   int                      line;
   int                      pos;
   int                      nv;
   int                      cnt;
   int                      err_count;
   int                      total_checks;
   int                      cyc;
   bit                      ident;
   bit                      ntsc;
   bit                      dbl;
   bit                      per;

   sc_seq_top i_sc_seq_top (
      .I_MCLK         (clk),
      .I_RST          (rst),
      .I_SC_SAMPLE    (sample),
      .I_AXI          (req),
      .O_AXI          (rsp),
      .O_LINES        (lines),
      .O_MEAS_WINDOW  (win),
      .O_BLANK        (blank),
      .O_BLANK_PERIOD (period),
      .O_FORCE_BLACK  (force_blk),
      .O_DARK_WINDOW  (dark),
      .O_AUX_LUMA     (luma),
      .O_SYNC_EN      (sync),
      .O_HUE_LEVEL    (hue_lvl)
   );

   sc_decoder_model i_sc_decoder_model (
      .i_clk    (clk),
      .o_sample (sample),
      .o_line   (line),
      .o_pos    (pos)
   );

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr_next

   // Expected insertion line of line k of the field
   function automatic logic [3:0] onehot(input int k);
      return (ident && k >= nv && k <= nv + 3) ? 4'h8 >> (k - nv) : 4'h0;
   endfunction : onehot

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // Ready sampled at negedge, so the decision never races the edge
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] er);
      bit aw;
      bit w;
      bit b;
      @(posedge clk);
      req.awaddr  <= a;
      req.awvalid <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= s;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(negedge clk);
         aw = req.awvalid && rsp.awready;
         w  = req.wvalid && rsp.wready;
         b  = rsp.bvalid === 1'b1;
         if (b) chk({30'h0, rsp.bresp}, {30'h0, er});
         @(posedge clk);
         if (aw) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end
      req.bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      bit ar;
      bit r;
      @(posedge clk);
      req.araddr  <= a;
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
      r = 1'b0;
      while (!r) begin
         @(negedge clk);
         ar = req.arvalid && rsp.arready;
         r  = rsp.rvalid === 1'b1;
         if (r) chk(rsp.rdata, ed);
         if (r) chk({30'h0, rsp.rresp}, {30'h0, er});
         @(posedge clk);
         if (ar) req.arvalid <= 1'b0;
      end
      req.rready <= 1'b0;
   endtask : axi_rd

   // Program the mode, then play one field; optionally read status in the red line
   task automatic run_field(input logic [3:0] c, input int n, input int len, input bit st);
      axi_wr(`REG_CTRL, {28'h0, c}, 4'h1, `RESP_OKAY);
      chk(luma, c[1]);
      chk(sync, c[1]);
      nv    = n;
      ident = n >= 2;
      ntsc  = c[2];
      dbl   = c[3];
      fork
         i_sc_decoder_model.field(c[0], n, len);
         if (st) begin
            while (!(line == n + 1 && pos == 12)) @(posedge clk);
            axi_rd(`REG_STATUS, ((n + 2) << 16) | 32'h1C, `RESP_OKAY);
         end
      join
   endtask : run_field

   // ****************************************
   // Reference model, compared every line from line 1
   // ****************************************
   always @(negedge clk) begin
      if (line >= 1 && pos == 30) begin
         exp_l = onehot(line);
         per   = ident && line <= nv + 3;
         cnt   = line + 1;
         chk(lines, exp_l);
         chk(win, |exp_l);
         chk(blank, per);
         chk(period, per);
         chk(force_blk, per ? 3'(~{exp_l[0], exp_l[1], exp_l[2]}) : 3'h0);
         chk(dark, ident && !per && cnt >= (16 << dbl)
             && cnt <= ((ntsc ? 224 : 272) << dbl));
      end
      if (line >= 1 && pos == 6) begin
         chk(lines, onehot(line - 1));
         chk(win, 1'b0);
      end
   end

   // Clock, 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Hang guard: whole run needs about 40000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      req          = '0;
      rst          = 1'b1;
      cyc          = 0;
      err_count    = 0;
      total_checks = 0;
      line         = -1;
      lfsr         = 16'h48FC;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      axi_rd(`REG_CTRL, 32'h2, `RESP_OKAY);
      axi_rd(`REG_HUE, 32'h3F, `RESP_OKAY);
      lfsr = lfsr_next(lfsr);
      hue  = lfsr[5:0];
      axi_wr(`REG_HUE, {lfsr, lfsr}, 4'hF, `RESP_OKAY);
      chk(hue_lvl, hue);
      axi_rd(`REG_HUE, {26'h0, hue}, `RESP_OKAY);
      axi_wr(`REG_HUE, 32'h0, 4'h0, `RESP_OKAY);
      chk(hue_lvl, hue);
      axi_wr(`REG_STATUS, 32'hFFFF_FFFF, 4'hF, `RESP_OKAY);
      axi_rd(`REG_STATUS, 32'h0, `RESP_OKAY);
      axi_wr(32'h0000_0010, 32'h1, 4'hF, `RESP_SLVERR);
      axi_rd(32'h0000_0010, 32'h0, `RESP_SLVERR);
      axi_wr(`REG_CTRL, 32'h0, 4'h1, `RESP_OKAY);
      chk(luma, 1'b0);
      chk(sync, 1'b0);
      // Luma black level wants the hue value at full scale
      axi_wr(`REG_HUE, 32'h3F, 4'h1, `RESP_OKAY);
      run_field(4'h2, 1, 12, 1'b0);
      run_field(4'h6, 2, 5, 1'b0);
      run_field(4'h6, 3, 230, 1'b1);
      run_field(4'h3, 2, 280, 1'b0);
      lfsr = lfsr_next(lfsr);
      run_field(4'hE, 2 + int'(lfsr % 3), 460, 1'b0);
      stop_test();
   end
endmodule : sandcastle_measurement_sequencer_bench
`default_nettype wire

// ==== verification/sc_decoder_model.sv ====
// Colour decoder model producing sandcastle sample codes
`timescale 1ns/1ps
`default_nettype none
module sc_decoder_model (
   input  wire logic       i_clk,
   output var  logic [7:0] o_sample,
   output var  int         o_line,
   output var  int         o_pos
);
   // ****************************************
   // Line shape: 40 cycles, H pulse 0..7
   // ****************************************
   localparam int LINE_LEN = 40;
   localparam int VERT_END = 20;

   // Idle: no pulse, no line in progress
   initial begin
      o_sample = 8'h00;
      o_line   = -1;
      o_pos    = 0;
   end

   // Vertical ends mid-line so its end never meets an H edge
   task automatic field(input bit two, input int nv, input int nlines);
      bit key;
      bit hp;
      bit vert;
      for (int k = 0; k < nlines; k++) begin
         for (int p = 0; p < LINE_LEN; p++) begin
            @(posedge i_clk);
            key  = (p >= 2) && (p <= 4);
            hp   = p < 8;
            vert = (k < nv - 1) || ((k == nv - 1) && (p < VERT_END));
            o_line <= k;
            o_pos  <= p;
            if (key) begin
               o_sample <= 8'hE0;
            end else if (two) begin
               o_sample <= (hp || vert) ? 8'h80 : 8'h00;
            end else begin
               o_sample <= hp ? 8'h90 : (vert ? 8'h50 : 8'h00);
            end
         end
      end
      @(posedge i_clk);
      o_sample <= 8'h00;
      o_line   <= -1;
   endtask : field
endmodule : sc_decoder_model
`default_nettype wire
